// ---- include/oag_pkg.sv ----
package oag_pkg;

    // addressing modes, sixteen in all
    typedef enum logic [3:0] {
        MODE_ABS       = 4'h0,
        MODE_ABS_X_IND = 4'h1,
        MODE_ABS_X     = 4'h2,
        MODE_ABS_Y     = 4'h3,
        MODE_ABS_IND   = 4'h4,
        MODE_ACC       = 4'h5,
        MODE_IMM       = 4'h6,
        MODE_IMPL      = 4'h7,
        MODE_REL       = 4'h8,
        MODE_STACK     = 4'h9,
        MODE_PZ        = 4'hA,
        MODE_PZ_X_IND  = 4'hB,
        MODE_PZ_X      = 4'hC,
        MODE_PZ_Y      = 4'hD,
        MODE_PZ_IND    = 4'hE,
        MODE_PZ_IND_Y  = 4'hF
    } oag_mode_e;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_FETCH_LO = 2'b01,
        ST_FETCH_HI = 2'b10,
        ST_FINISH   = 2'b11
    } oag_state_e;

    // page numbers
    localparam logic [7:0] PAGE_ZERO  = 8'h00;
    localparam logic [7:0] PAGE_STACK = 8'h01;

    // cycle penalties
    localparam logic [3:0] PEN_PAGE  = 4'h1;
    localparam logic [3:0] PEN_STORE = 4'h1;
    localparam logic [3:0] PEN_TAKEN = 4'h1;
    localparam logic [3:0] PEN_RMW   = 4'h2;

    // software break length and ignored signature byte
    localparam logic [1:0]  BREAK_BYTES = 2'h2;
    localparam logic [15:0] BREAK_SKIP  = 16'h0002;

    // cycles from request to done
    localparam int DIRECT_LATENCY  = 1;
    localparam int POINTER_LATENCY = 4;

    // reset values
    localparam logic [15:0] RST_ADDR   = 16'h0000;
    localparam logic [3:0]  RST_CYCLES = 4'h0;
    localparam logic [1:0]  RST_BYTES  = 2'h0;

    // base cycle count per mode, stack taken at its least
    function automatic logic [3:0] baseCycles(input oag_mode_e m);
        case (m)
            MODE_ABS, MODE_ABS_X, MODE_ABS_Y,
            MODE_PZ_X, MODE_PZ_Y:                 baseCycles = 4'h4;
            MODE_ABS_X_IND, MODE_ABS_IND,
            MODE_PZ_X_IND:                        baseCycles = 4'h6;
            MODE_PZ_IND, MODE_PZ_IND_Y:           baseCycles = 4'h5;
            MODE_STACK, MODE_PZ:                  baseCycles = 4'h3;
            default:                              baseCycles = 4'h2;
        endcase
    endfunction

    // instruction length per mode
    function automatic logic [1:0] instrBytes(input oag_mode_e m);
        case (m)
            MODE_ABS, MODE_ABS_X_IND, MODE_ABS_X,
            MODE_ABS_Y, MODE_ABS_IND:             instrBytes = 2'h3;
            MODE_ACC, MODE_IMPL, MODE_STACK:      instrBytes = 2'h1;
            default:                              instrBytes = 2'h2;
        endcase
    endfunction

    // modes that read a pointer from memory
    function automatic logic usesPointer(input oag_mode_e m);
        usesPointer = (m == MODE_ABS_X_IND) || (m == MODE_ABS_IND) ||
                      (m == MODE_PZ_X_IND) || (m == MODE_PZ_IND) || (m == MODE_PZ_IND_Y);
    endfunction

    // high bytes differ
    function automatic logic crossesPage(input logic [15:0] a, input logic [15:0] b);
        crossesPage = (a[15:8] != b[15:8]);
    endfunction

endpackage

// ---- hdl/oag_ptr_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module oag_ptr_mem (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // write port
    input  wire logic       wrEn,
    input  wire logic       wrIdx,
    input  wire logic [7:0] wrData,
    // combinational read of both cells
    output logic      [7:0] rdLo,
    output logic      [7:0] rdHi
);

    logic [7:0] cell_ff [0:1];

    // two pointer bytes, low at index 0
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cell_ff[0] <= 8'h00;
            cell_ff[1] <= 8'h00;
        end
        else if (wrEn)
        begin
            cell_ff[wrIdx] <= wrData;
        end
    end

    assign rdLo = cell_ff[0];
    assign rdHi = cell_ff[1];

endmodule

`default_nettype wire

// ---- hdl/oag_top.sv ----

`timescale 1ns/1ps
`default_nettype none

module oag_top (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // request
    input  wire logic                reqValid,
    output logic                     reqReady,
    input  wire oag_pkg::oag_mode_e  reqMode,
    input  wire logic [7:0]          opByteLo,
    input  wire logic [7:0]          opByteHi,
    input  wire logic [7:0]          idxX,
    input  wire logic [7:0]          idxY,
    input  wire logic [15:0]         pcIn,
    input  wire logic                isRmwOp,
    input  wire logic                isStoreAccumulatorOp,
    input  wire logic                isSoftwareBreakOp,
    input  wire logic                branchTaken,
    // pointer memory
    output logic                     memRdEn,
    output logic [15:0]              memAddr,
    input  wire logic [7:0]          memRdata,
    // result
    output logic                     done,
    output logic [15:0]              effAddr,
    output logic                     pageCross,
    output logic [3:0]               cycleCount,
    output logic [1:0]               byteCount,
    output logic [15:0]              nextPc,
    output logic [15:0]              resumeAddr,
    output logic [15:0]              fetchedPtr
);

    oag_pkg::oag_state_e state_ff;
    oag_pkg::oag_mode_e  mode_ff;
    oag_pkg::oag_mode_e  srcMode;
    logic [7:0]  lo_ff, hi_ff, x_ff, y_ff, srcLo, srcHi, srcX, srcY, pzSum, ptrLo, ptrHi;
    logic [15:0] pc_ff, srcPc, seqPc, base16, ptrWord, nxtEff, nxtPc, firstPtr;
    logic        rmw_ff, storeOp_ff, breakOp_ff, taken_ff, srcRmw, srcStore, srcBreak, srcTaken;
    logic        nxtCross, accept, load, ptrWr;
    logic [3:0]  nxtCycles;
    logic [1:0]  nxtBytes;

    assign reqReady = (state_ff == oag_pkg::ST_IDLE);
    assign accept   = reqValid && reqReady;
    assign load     = (accept && !oag_pkg::usesPointer(reqMode)) || (state_ff == oag_pkg::ST_FINISH);
    assign ptrWr    = (state_ff == oag_pkg::ST_FETCH_HI) || (state_ff == oag_pkg::ST_FINISH);

    // held request fields
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_ff  <= oag_pkg::MODE_IMPL;
            lo_ff    <= 8'h00;
            hi_ff    <= 8'h00;
            x_ff     <= 8'h00;
            y_ff     <= 8'h00;
            pc_ff    <= oag_pkg::RST_ADDR;
            rmw_ff     <= 1'b0;
            storeOp_ff <= 1'b0;
            breakOp_ff <= 1'b0;
            taken_ff <= 1'b0;
        end
        else if (accept)
        begin
            mode_ff  <= reqMode;
            lo_ff    <= opByteLo;
            hi_ff    <= opByteHi;
            x_ff     <= idxX;
            y_ff     <= idxY;
            pc_ff    <= pcIn;
            rmw_ff   <= isRmwOp;
            storeOp_ff <= isStoreAccumulatorOp;
            breakOp_ff <= isSoftwareBreakOp;
            taken_ff <= branchTaken;
        end
    end

    // request fields live in idle, held ones afterwards
    always_comb
    begin
        if (reqReady)
        begin
            srcMode = reqMode;   srcLo = opByteLo; srcHi = opByteHi; srcX = idxX; srcY = idxY;
            srcPc = pcIn;        srcRmw = isRmwOp; srcStore = isStoreAccumulatorOp;
            srcBreak = isSoftwareBreakOp; srcTaken = branchTaken;
        end
        else
        begin
            srcMode = mode_ff;   srcLo = lo_ff;    srcHi = hi_ff;    srcX = x_ff; srcY = y_ff;
            srcPc = pc_ff;       srcRmw = rmw_ff;  srcStore = storeOp_ff;
            srcBreak = breakOp_ff; srcTaken = taken_ff;
        end
    end

    // first pointer byte address
    always_comb
    begin
        case (reqMode)
            oag_pkg::MODE_ABS_IND:   firstPtr = {opByteHi, opByteLo};
            oag_pkg::MODE_ABS_X_IND: firstPtr = {opByteHi, opByteLo} + {8'h00, idxX};
            oag_pkg::MODE_PZ_X_IND:  firstPtr = {oag_pkg::PAGE_ZERO, 8'(opByteLo + idxX)};
            default:                 firstPtr = {oag_pkg::PAGE_ZERO, opByteLo};
        endcase
    end

    // pointer fetch sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= oag_pkg::ST_IDLE;
        end
        else
        begin
            case (state_ff)
                oag_pkg::ST_IDLE:     if (accept && oag_pkg::usesPointer(reqMode)) state_ff <= oag_pkg::ST_FETCH_LO;
                oag_pkg::ST_FETCH_LO: state_ff <= oag_pkg::ST_FETCH_HI;
                oag_pkg::ST_FETCH_HI: state_ff <= oag_pkg::ST_FINISH;
                default:              state_ff <= oag_pkg::ST_IDLE;
            endcase
        end
    end

    // memory address and read strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            memAddr <= oag_pkg::RST_ADDR;
            memRdEn <= 1'b0;
        end
        else if (accept && oag_pkg::usesPointer(reqMode))
        begin
            memAddr <= firstPtr;
            memRdEn <= 1'b1;
        end
        else if (state_ff == oag_pkg::ST_FETCH_LO)
        begin
            memAddr <= (mode_ff == oag_pkg::MODE_ABS_IND || mode_ff == oag_pkg::MODE_ABS_X_IND)
                       ? memAddr + 16'h0001 : {oag_pkg::PAGE_ZERO, 8'(memAddr[7:0] + 8'h01)};
        end
        else if (state_ff == oag_pkg::ST_FETCH_HI)
        begin
            memRdEn <= 1'b0;
        end
    end

    // pointer bytes captured as they arrive
    oag_ptr_mem u_ptr (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (ptrWr),
        .wrIdx  (state_ff == oag_pkg::ST_FINISH),
        .wrData (memRdata),
        .rdLo   (ptrLo),
        .rdHi   (ptrHi)
    );

    assign ptrWord    = {memRdata, ptrLo};
    assign fetchedPtr = {ptrHi, ptrLo};

    // effective address and penalties
    always_comb
    begin
        base16   = {srcHi, srcLo};
        pzSum    = 8'h00;
        nxtCross = 1'b0;
        nxtBytes = srcBreak ? oag_pkg::BREAK_BYTES : oag_pkg::instrBytes(srcMode);
        seqPc    = srcBreak ? srcPc + oag_pkg::BREAK_SKIP : srcPc + {14'h0000, nxtBytes};
        case (srcMode)
            oag_pkg::MODE_ABS:   nxtEff = base16;
            oag_pkg::MODE_ABS_X:
            begin
                nxtEff   = base16 + {8'h00, srcX};
                nxtCross = oag_pkg::crossesPage(base16, nxtEff);
            end
            oag_pkg::MODE_ABS_Y:
            begin
                nxtEff   = base16 + {8'h00, srcY};
                nxtCross = oag_pkg::crossesPage(base16, nxtEff);
            end
            oag_pkg::MODE_ABS_IND, oag_pkg::MODE_ABS_X_IND,
            oag_pkg::MODE_PZ_IND, oag_pkg::MODE_PZ_X_IND: nxtEff = ptrWord;
            oag_pkg::MODE_PZ_IND_Y:
            begin
                nxtEff   = ptrWord + {8'h00, srcY};
                nxtCross = oag_pkg::crossesPage(ptrWord, nxtEff);
            end
            oag_pkg::MODE_IMM:   nxtEff = srcPc + 16'h0001;
            oag_pkg::MODE_REL:
            begin
                nxtEff   = seqPc + {{8{srcLo[7]}}, srcLo};
                nxtCross = srcTaken && oag_pkg::crossesPage(seqPc, nxtEff);
            end
            oag_pkg::MODE_STACK: nxtEff = {oag_pkg::PAGE_STACK, srcLo};
            oag_pkg::MODE_PZ:    nxtEff = {oag_pkg::PAGE_ZERO, srcLo};
            oag_pkg::MODE_PZ_X:
            begin
                pzSum  = srcLo + srcX;
                nxtEff = {oag_pkg::PAGE_ZERO, pzSum};
            end
            oag_pkg::MODE_PZ_Y:
            begin
                pzSum  = srcLo + srcY;
                nxtEff = {oag_pkg::PAGE_ZERO, pzSum};
            end
            default:             nxtEff = oag_pkg::RST_ADDR;
        endcase
        nxtPc = (srcMode == oag_pkg::MODE_REL && srcTaken) ? nxtEff : seqPc;
        // store in absolute X always pays
        nxtCycles = oag_pkg::baseCycles(srcMode)
                  + ((srcStore && srcMode == oag_pkg::MODE_ABS_X) ? oag_pkg::PEN_STORE
                     : (nxtCross ? oag_pkg::PEN_PAGE : 4'h0))
                  + ((srcMode == oag_pkg::MODE_REL && srcTaken) ? oag_pkg::PEN_TAKEN : 4'h0)
                  + (srcRmw ? oag_pkg::PEN_RMW : 4'h0);
    end

    // result registers and done pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done       <= 1'b0;
            effAddr    <= oag_pkg::RST_ADDR;
            pageCross  <= 1'b0;
            cycleCount <= oag_pkg::RST_CYCLES;
            byteCount  <= oag_pkg::RST_BYTES;
            nextPc     <= oag_pkg::RST_ADDR;
            resumeAddr <= oag_pkg::RST_ADDR;
        end
        else
        begin
            done <= load;
            if (load)
            begin
                effAddr    <= nxtEff;
                pageCross  <= nxtCross;
                cycleCount <= nxtCycles;
                byteCount  <= nxtBytes;
                nextPc     <= nxtPc;
                resumeAddr <= seqPc;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // checks on finished results, on the pointer fetch address and on direct-mode latency
    AST_PZ_X: assert property (done && mode_ff == oag_pkg::MODE_PZ_X && !rmw_ff |->
        effAddr == {8'h00, 8'(lo_ff + x_ff)} && cycleCount == 4'h4 && byteCount == 2'h2)
        else $error("page-zero X result wrong");
    AST_PZ_Y: assert property (done && mode_ff == oag_pkg::MODE_PZ_Y |->
        effAddr == {8'h00, 8'(lo_ff + y_ff)} && cycleCount == (rmw_ff ? 4'h6 : 4'h4))
        else $error("page-zero Y result wrong");
    AST_PZ_IND: assert property (accept && reqMode == oag_pkg::MODE_PZ_IND && !isRmwOp |->
        ##4 done && cycleCount == 4'h5 && byteCount == 2'h2)
        else $error("page-zero indirect timing wrong");
    AST_PZ_IND_Y: assert property (done && mode_ff == oag_pkg::MODE_PZ_IND_Y && !rmw_ff |->
        cycleCount == 4'(5 + pageCross) && effAddr == fetchedPtr + {8'h00, y_ff})
        else $error("indirect Y result wrong");
    AST_PZ_X_IND: assert property (done && mode_ff == oag_pkg::MODE_PZ_X_IND |->
        $past(memAddr, 3) == {8'h00, 8'(lo_ff + x_ff)} && effAddr == fetchedPtr)
        else $error("X indirect pointer address wrong");
    AST_ABS_X_IND: assert property (done && mode_ff == oag_pkg::MODE_ABS_X_IND && !rmw_ff |->
        cycleCount == 4'h6 && byteCount == 2'h3)
        else $error("absolute X indirect count wrong");
    AST_ABS_IND: assert property (done && mode_ff == oag_pkg::MODE_ABS_IND && !rmw_ff |->
        cycleCount == 4'h6 && nextPc == pc_ff + 16'h0003)
        else $error("absolute indirect count wrong");
    AST_ABS_IDX: assert property (done && mode_ff == oag_pkg::MODE_ABS_Y && !rmw_ff |->
        byteCount == 2'h3 && effAddr == {hi_ff, lo_ff} + {8'h00, y_ff})
        else $error("absolute Y result wrong");
    AST_PAGE: assert property (done && mode_ff == oag_pkg::MODE_ABS_Y && !rmw_ff |->
        cycleCount == (pageCross ? 4'h5 : 4'h4) && pageCross == (effAddr[15:8] != hi_ff))
        else $error("page penalty wrong");
    AST_STORE: assert property (done && mode_ff == oag_pkg::MODE_ABS_X && storeOp_ff && !rmw_ff |->
        cycleCount == 4'h5)
        else $error("store penalty wrong");
    AST_BRANCH: assert property (done && mode_ff == oag_pkg::MODE_REL |->
        cycleCount == 4'(2 + taken_ff + pageCross + (rmw_ff ? 2 : 0)) && (taken_ff || nextPc == pc_ff + 16'h0002))
        else $error("branch timing wrong");
    AST_RMW: assert property (done && mode_ff == oag_pkg::MODE_PZ && rmw_ff |->
        cycleCount == 4'h5)
        else $error("read-modify-write penalty wrong");
    AST_BREAK: assert property (done && breakOp_ff |->
        byteCount == 2'h2 && nextPc == pc_ff + 16'h0002)
        else $error("break length wrong");
    AST_RESUME: assert property (done && breakOp_ff |-> resumeAddr == pc_ff + 16'h0002)
        else $error("break resume address wrong");
    AST_WRAP: assert property (state_ff == oag_pkg::ST_FETCH_HI && mode_ff != oag_pkg::MODE_ABS_IND &&
        mode_ff != oag_pkg::MODE_ABS_X_IND |-> memAddr[15:8] == 8'h00 && memAddr[7:0] == 8'($past(memAddr[7:0]) + 8'h01))
        else $error("page-zero pointer did not wrap");
    AST_DIRECT: assert property (accept && !oag_pkg::usesPointer(reqMode) |=> done && reqReady)
        else $error("direct mode latency wrong");

    // main scenarios
    COV_PTR: cover property (accept && reqMode == oag_pkg::MODE_PZ_IND_Y ##4 done && pageCross);
    COV_BRANCH: cover property (done && mode_ff == oag_pkg::MODE_REL && taken_ff && pageCross);
    COV_BREAK: cover property (done && breakOp_ff);
    COV_WRAP: cover property (done && mode_ff == oag_pkg::MODE_PZ_X && (lo_ff + x_ff > 9'h0FF));

endmodule

`default_nettype wire

// ---- test/oag_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module oag_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // read request
    input  wire logic        memRdEn,
    input  wire logic [15:0] memAddr,
    // read data
    output logic      [7:0]  memRdata
);
    // answers one cycle after the strobe; a released bus keeps toggling so stale data never matches
    always_ff @(posedge clk)
    begin
        if (rst)
            memRdata <= 8'hC3;
        else if (memRdEn)
            memRdata <= memAddr[7:0] ^ {memAddr[11:8], memAddr[15:12]} ^ 8'h5A;
        else
            memRdata <= ~memRdata;
    end
endmodule

`default_nettype wire

// ---- test/tb_operand_address_generator.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_operand_address_generator;
    // clock, reset and request side
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               reqValid = 1'b0;
    logic               reqReady;
    oag_pkg::oag_mode_e reqMode = oag_pkg::MODE_ABS;
    logic [7:0]         opByteLo = 8'h00, opByteHi = 8'h00, idxX = 8'h00, idxY = 8'h00;
    logic [15:0]        pcIn = 16'h0000;
    logic               isRmwOp = 1'b0, isStoreAccumulatorOp = 1'b0, isSoftwareBreakOp = 1'b0, branchTaken = 1'b0;
    // memory and results
    logic               memRdEn, pageCross, done;
    logic [15:0]        memAddr, effAddr, nextPc, resumeAddr, fetchedPtr;
    logic [7:0]         memRdata;
    logic [3:0]         cycleCount;
    logic [1:0]         byteCount;
    int                 miscompares = 0;
    int                 comparisons = 0;
    int                 i;
    oag_pkg::oag_mode_e rndMode;

    // 10 MHz clock
    always #50 clk = ~clk;

    oag_top i_oag_top (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady), .reqMode(reqMode),
        .opByteLo(opByteLo), .opByteHi(opByteHi), .idxX(idxX), .idxY(idxY), .pcIn(pcIn), .isRmwOp(isRmwOp),
        .isStoreAccumulatorOp(isStoreAccumulatorOp), .isSoftwareBreakOp(isSoftwareBreakOp),
        .branchTaken(branchTaken), .memRdEn(memRdEn), .memAddr(memAddr), .memRdata(memRdata), .done(done),
        .effAddr(effAddr), .pageCross(pageCross), .cycleCount(cycleCount), .byteCount(byteCount),
        .nextPc(nextPc), .resumeAddr(resumeAddr), .fetchedPtr(fetchedPtr));

    oag_mem_model i_oag_mem_model (.clk(clk), .rst(rst), .memRdEn(memRdEn), .memAddr(memAddr),
        .memRdata(memRdata));

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one comparison
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("ERROR %0t %s mode %0d", $time, what, reqMode);
        end
    endtask

    // byte the memory model holds at an address
    function automatic logic [7:0] memByte(input logic [15:0] a);
        memByte = a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
    endfunction

    // two-byte pointer, low byte first; page-zero reads wrap inside the page
    function automatic logic [15:0] ptrAt(input logic [15:0] a, input logic pz);
        logic [15:0] b;
        b = pz ? {8'h00, a[7:0] + 8'h01} : a + 16'h0001;
        ptrAt = {memByte(b), memByte(a)};
    endfunction

    // one request with its expected results; fl = {rmw, store, break, taken}
    task automatic req(input oag_pkg::oag_mode_e m, input logic [7:0] lo, hi, x, y,
                       input logic [15:0] pc, input logic [3:0] fl);
        logic [15:0] ea, ptr, tgt, np2;
        logic [3:0]  cyc;
        logic [1:0]  nb;
        logic        crs, isPtr;
        int          lat;
        reqMode = m; opByteLo = lo; opByteHi = hi; idxX = x; idxY = y; pcIn = pc;
        {isRmwOp, isStoreAccumulatorOp, isSoftwareBreakOp, branchTaken} = fl;
        reqValid = 1'b1;
        np2 = pc + 16'h0002;
        tgt = np2 + {{8{lo[7]}}, lo};
        crs = 1'b0;
        ptr = 16'h0000;
        isPtr = m inside {oag_pkg::MODE_ABS_IND, oag_pkg::MODE_ABS_X_IND, oag_pkg::MODE_PZ_IND,
                          oag_pkg::MODE_PZ_X_IND, oag_pkg::MODE_PZ_IND_Y};
        // expected address and base cycles per mode
        case (m)
            oag_pkg::MODE_ABS:       begin ea = {hi, lo}; cyc = 4'h4; end
            oag_pkg::MODE_ABS_X_IND: begin ptr = ptrAt({hi, lo} + {8'h00, x}, 1'b0); ea = ptr; cyc = 4'h6; end
            oag_pkg::MODE_ABS_X:     begin ea = {hi, lo} + {8'h00, x}; crs = ea[15:8] != hi; cyc = 4'h4; end
            oag_pkg::MODE_ABS_Y:     begin ea = {hi, lo} + {8'h00, y}; crs = ea[15:8] != hi; cyc = 4'h4; end
            oag_pkg::MODE_ABS_IND:   begin ptr = ptrAt({hi, lo}, 1'b0); ea = ptr; cyc = 4'h6; end
            oag_pkg::MODE_IMM:       begin ea = pc + 16'h0001; cyc = 4'h2; end
            oag_pkg::MODE_REL:       begin ea = tgt; crs = fl[0] & (tgt[15:8] != np2[15:8]); cyc = 4'h2 + fl[0]; end
            oag_pkg::MODE_STACK:     begin ea = {8'h01, lo}; cyc = 4'h3; end
            oag_pkg::MODE_PZ:        begin ea = {8'h00, lo}; cyc = 4'h3; end
            oag_pkg::MODE_PZ_X_IND:  begin ptr = ptrAt({8'h00, lo + x}, 1'b1); ea = ptr; cyc = 4'h6; end
            oag_pkg::MODE_PZ_X:      begin ea = {8'h00, lo + x}; cyc = 4'h4; end
            oag_pkg::MODE_PZ_Y:      begin ea = {8'h00, lo + y}; cyc = 4'h4; end
            oag_pkg::MODE_PZ_IND:    begin ptr = ptrAt({8'h00, lo}, 1'b1); ea = ptr; cyc = 4'h5; end
            oag_pkg::MODE_PZ_IND_Y:
            begin
                ptr = ptrAt({8'h00, lo}, 1'b1); ea = ptr + {8'h00, y}; crs = ea[15:8] != ptr[15:8]; cyc = 4'h5;
            end
            default:                 begin ea = 16'h0000; cyc = 4'h2; end
        endcase
        cyc = cyc + ((m == oag_pkg::MODE_ABS_X && fl[2]) ? 4'h1 : {3'h0, crs}) + (fl[3] ? 4'h2 : 4'h0);
        nb = (4'(m) <= 4'h4) ? 2'h3 : (m inside {oag_pkg::MODE_ACC, oag_pkg::MODE_IMPL, oag_pkg::MODE_STACK}) ? 2'h1 : 2'h2;
        nb = fl[1] ? 2'h2 : nb;
        // ready seen off the edge, taken at the next edge, then count edges to done
        for (lat = 0; lat < 20 && reqReady !== 1'b1; lat++)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 reqValid = 1'b0;
        for (lat = 1; lat < 20 && done !== 1'b1; lat++)
        begin
            @(posedge clk);
            #1;
        end
        check(lat == (isPtr ? oag_pkg::POINTER_LATENCY : oag_pkg::DIRECT_LATENCY), "latency");
        check(effAddr === ea, "effective address"); // address
        check(cycleCount === cyc, "cycle count"); // cycles
        check(byteCount === nb, "byte count"); // length
        check(nextPc === ((m == oag_pkg::MODE_REL && fl[0]) ? tgt : pc + 16'(nb)), "next pc"); // pc
        check(resumeAddr === pc + 16'(nb), "resume address"); // resume point
        check(pageCross === crs, "page cross"); // crossing flag
        // one edge passes so valid is not raised again in this time step
        @(posedge clk);
        #1;
        check(done === 1'b0, "done pulse length");
        if (isPtr)
            check(fetchedPtr === ptr, "fetched pointer"); // pointer
    endtask

    // run limit
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end

    // main sequence
    initial
    begin
        void'($urandom(63269));
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check(reqReady === 1'b1 && done === 1'b0 && memRdEn === 1'b0 && effAddr === 16'h0000, "reset values");
        $display("test reset done");
        // page wraps, crossings, penalties and break
        req(oag_pkg::MODE_PZ_X, 8'hF0, 8'h55, 8'h20, 8'h00, 16'h0200, 4'h0); // wrap
        req(oag_pkg::MODE_PZ_Y, 8'hFF, 8'h55, 8'h00, 8'hFF, 16'h0200, 4'h8); // wrap
        req(oag_pkg::MODE_PZ_IND, 8'hFF, 8'h00, 8'h00, 8'h00, 16'h0300, 4'h0); // pointer wrap
        req(oag_pkg::MODE_PZ_X_IND, 8'h80, 8'h00, 8'h7F, 8'h00, 16'h0300, 4'h0); // pointer wrap
        req(oag_pkg::MODE_PZ_IND_Y, 8'h10, 8'h00, 8'h00, 8'hFF, 16'h0300, 4'h0); // crossing
        req(oag_pkg::MODE_ABS_X, 8'hF0, 8'h12, 8'h20, 8'h00, 16'h0400, 4'h0); // crossing
        req(oag_pkg::MODE_ABS_X, 8'h00, 8'h12, 8'h01, 8'h00, 16'h0400, 4'h4); // store penalty
        req(oag_pkg::MODE_ABS_Y, 8'hFF, 8'h34, 8'h00, 8'h01, 16'h0400, 4'h8); // penalties
        req(oag_pkg::MODE_ABS_IND, 8'hFF, 8'h12, 8'h00, 8'h00, 16'h0500, 4'h0); // pointer carry
        req(oag_pkg::MODE_ABS_X_IND, 8'hFE, 8'h20, 8'h03, 8'h00, 16'h0500, 4'h0); // indexed pointer
        req(oag_pkg::MODE_REL, 8'h80, 8'h00, 8'h00, 8'h00, 16'h1200, 4'h1); // taken crossing
        req(oag_pkg::MODE_REL, 8'h10, 8'h00, 8'h00, 8'h00, 16'h1200, 4'h0); // not taken
        req(oag_pkg::MODE_IMPL, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 4'h2); // break
        $display("test corners done");
        // every mode, then a random mix
        for (i = 0; i < 316; i++)
        begin
            rndMode = oag_pkg::oag_mode_e'((i < 16) ? i[3:0] : 4'($urandom_range(15, 0)));
            // break flag only with the implied mode, where the break instruction lives
            req(rndMode, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom),
                4'($urandom) & ((rndMode == oag_pkg::MODE_IMPL) ? 4'hF : 4'hD));
        end
        $display("test random done");
        summarize();
    end
endmodule

`default_nettype wire
